// file: cfec_top.sv
/*
 Fill syndrome capture, read by privileged register accesses, and
 backup-cache tag probe capture, read and written by them.
 Assumes probe results and fill data arrive from bus interface logic on
 clk_sys, and software spaces tag capture reads by an idle cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module cfec_top
  import cfec_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  input  wire logic              ecc_mode,
  input  wire logic [2:0]        cache_size_field,
  input  wire cfec_fill_t        fill_in,
  input  wire cfec_probe_t       probe_in,
  input  wire logic              fill_addr_read,
  input  wire logic              privileged_reg_read,
  input  wire logic              privileged_reg_write,
  input  wire logic [4:0]        reg_index,
  output logic      [RD_W-1:0]   rd_data,
  output logic                   rd_valid,
  output logic                   syn_locked,
  output logic                   tag_locked
);

  //////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic logic idx_hit(input logic [4:0] idx,
                                   input logic [4:0] want);
    idx_hit = (idx == want);
  endfunction

  // Low tag bits fall into the index for bigger caches
  function automatic logic [TAG_W-1:0] tag_mask(input logic [2:0] sz);
    logic [2:0] s;
    s = (sz > SIZE_MAX) ? SIZE_MAX : sz;
    for (int i = 0; i < TAG_W; i++)
      tag_mask[i] = (i >= int'(s));
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Syndrome generation per longword

  logic [SYN_W-1:0] syn_lw [2];

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_lw
      cfec_syn_calc u_calc (
        .data     (fill_in.data[32*g +: 32]),
        .check    (fill_in.check[SYN_W*g +: SYN_W]),
        .ecc_mode (ecc_mode),
        .syn      (syn_lw[g])
      );
    end
  endgenerate

  logic [13:0] syn_now;
  logic        fill_err;

  always_comb
  begin
    syn_now = '0;
    syn_now[POS_HI_SYN +: SYN_W] = syn_lw[1];
    syn_now[POS_LO_SYN +: SYN_W] = syn_lw[0];
    // Zero halves mean clean longwords, so only nonzero is an error
    fill_err = fill_in.valid && (syn_now != 14'h0000);
  end

  //////////////////////////////////////////////////////////////////////
  // Fill syndrome register

  logic [13:0] syn_r;
  logic [13:0] syn_nxt;
  logic        syn_lock_r;
  logic        syn_lock_nxt;

  always_comb
  begin
    syn_nxt      = syn_r;
    syn_lock_nxt = syn_lock_r;
    if (fill_addr_read)
      syn_lock_nxt = 1'b0;
    // A new error in the release cycle is kept, not lost
    if (fill_err && (!syn_lock_r || fill_addr_read))
    begin
      syn_nxt      = syn_now;
      syn_lock_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      syn_r      <= SYN_RST;
      syn_lock_r <= LOCK_RST;
    end
    else
    begin
      syn_r      <= syn_nxt;
      syn_lock_r <= syn_lock_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Tag probe capture register

  logic      tag_rd;
  logic      tag_wr;
  logic      probe_err;
  cfec_tag_t tag_now;
  cfec_tag_t tag_r;
  cfec_tag_t tag_nxt;
  logic      tag_lock_r;
  logic      tag_lock_nxt;

  always_comb
  begin
    tag_rd    = privileged_reg_read && idx_hit(reg_index, IDX_TAG_CAPT);
    tag_wr    = privileged_reg_write && idx_hit(reg_index, IDX_TAG_CAPT);
    probe_err = probe_in.valid &&
                (probe_in.tag_par_err || probe_in.ctl_par_err);
    tag_now.captured_tag_addr_parity = probe_in.tag_addr_parity_pin;
    tag_now.tag = probe_in.tag & tag_mask(cache_size_field);
    tag_now.captured_valid_bit  = probe_in.valid_status_pin;
    tag_now.captured_shared_bit = probe_in.shared_status_pin;
    tag_now.captured_dirty_bit  = probe_in.dirty_status_pin;
    tag_now.captured_ctl_parity = probe_in.status_parity_pin;
    tag_now.hit = probe_in.hit;
  end

  always_comb
  begin
    tag_nxt      = tag_r;
    tag_lock_nxt = tag_lock_r;
    if (tag_wr)
      tag_lock_nxt = 1'b0;
    // Lock beats an unlock in the same cycle
    if (probe_err || fill_err)
      tag_lock_nxt = 1'b1;
    // A probe load overrides a shift in the same cycle
    if (probe_in.valid && !tag_lock_r)
      tag_nxt = tag_now;
    else if (tag_rd)
      tag_nxt = cfec_tag_t'({1'b0, tag_r[TAGREG_W-1:1]});
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      tag_r      <= TAG_RST;
      tag_lock_r <= LOCK_RST;
    end
    else
    begin
      tag_r      <= tag_nxt;
      tag_lock_r <= tag_lock_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Read port

  logic [RD_W-1:0] rd_data_r;
  logic [RD_W-1:0] rd_data_nxt;
  logic            rd_valid_r;

  always_comb
  begin
    rd_data_nxt = rd_data_r;
    if (privileged_reg_read)
    begin
      if (idx_hit(reg_index, IDX_FILL_ERROR_SYNDROME))
        rd_data_nxt = {18'h0_0000, syn_r};
      else if (tag_rd)
        rd_data_nxt = {31'h0000_0000, tag_r[0]};
      else
        rd_data_nxt = '0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_data_r  <= '0;
      rd_valid_r <= 1'b0;
    end
    else
    begin
      rd_data_r  <= rd_data_nxt;
      rd_valid_r <= privileged_reg_read;
    end
  end

  assign rd_data    = rd_data_r;
  assign rd_valid   = rd_valid_r;
  assign syn_locked = syn_lock_r;
  assign tag_locked = tag_lock_r;

  //////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  a_syn_capture: assert property (
    fill_err && !syn_lock_r |=> syn_locked && syn_r == $past(syn_now))
    else $error("fill syndrome not captured");

  a_syn_hold: assert property (
    syn_lock_r && !fill_addr_read |=> syn_locked && $stable(syn_r))
    else $error("locked syndrome changed");

  a_syn_release: assert property (
    fill_addr_read && !fill_err |=> !syn_locked)
    else $error("syndrome lock not released");

  a_syn_nonzero: assert property (
    syn_locked |-> syn_r != 14'h0000)
    else $error("locked syndrome is zero");

  a_parity_form: assert property (
    fill_err && !syn_lock_r && !ecc_mode
    |=> syn_r[13:8] == 6'h00 && syn_r[6:1] == 6'h00)
    else $error("parity mode syndrome bits not zero");

  a_tag_load: assert property (
    probe_in.valid && !tag_lock_r
    |=> tag_r.tag == $past(probe_in.tag & tag_mask(cache_size_field))
        && tag_r.hit == $past(probe_in.hit))
    else $error("tag probe not loaded");

  a_tag_lock: assert property (
    probe_err || fill_err |=> tag_locked ##1 (tag_locked || $past(tag_wr)))
    else $error("tag capture not locked by error");

  a_tag_frozen: assert property (
    tag_lock_r && !tag_rd |=> $stable(tag_r))
    else $error("locked tag capture changed");

  a_tag_shift: assert property (
    tag_rd && !(probe_in.valid && !tag_lock_r)
    |=> tag_r == ($past(tag_r) >> 1))
    else $error("tag capture did not shift");

  a_read_lsb: assert property (
    tag_rd |=> rd_valid && rd_data == {31'h0000_0000, $past(tag_r[0])})
    else $error("tag read did not return lsb");

  a_tag_unlock: assert property (
    tag_wr && !probe_err && !fill_err |=> !tag_locked)
    else $error("tag lock not cleared by write");

  // Other indexes must never release the tag lock
  a_write_other: assert property (
    privileged_reg_write && reg_index != IDX_TAG_CAPT && tag_lock_r
    |=> tag_locked)
    else $error("tag lock cleared by foreign write");

  a_read_answer: assert property (
    privileged_reg_read |=> rd_valid)
    else $error("read not answered");

  a_read_quiet: assert property (
    !privileged_reg_read |=> !rd_valid)
    else $error("read valid without read");

  a_synd_readback: assert property (
    privileged_reg_read && reg_index == IDX_FILL_ERROR_SYNDROME
    |=> rd_data == {18'h0_0000, $past(syn_r)})
    else $error("fill syndrome read back wrong");

  a_clean_fill: assert property (
    fill_in.valid && !fill_err && !syn_lock_r |=> !syn_locked)
    else $error("clean fill locked syndrome");

  // In ECC mode, with zero data the syndrome is the received check bits
  a_check_only: assert property (
    fill_in.valid && ecc_mode && !syn_lock_r && fill_in.data == 64'h0000_0000_0000_0000
    && fill_in.check != 14'h0000 |=> syn_r == $past(fill_in.check))
    else $error("check bit syndrome wrong");

  a_parity_flag: assert property (
    fill_err && !syn_lock_r && !ecc_mode |=> syn_r[7] || syn_r[0])
    else $error("parity capture flags no longword");

  a_unused_tag: assert property (
    probe_in.valid && !tag_lock_r && cache_size_field == 3'h3
    |=> tag_r.tag[2:0] == 3'h0)
    else $error("unused tag bits not clear");

  a_pin_capture: assert property (
    probe_in.valid && !tag_lock_r
    |=> tag_r.captured_tag_addr_parity == $past(probe_in.tag_addr_parity_pin)
        && tag_r.captured_ctl_parity == $past(probe_in.status_parity_pin))
    else $error("probe pin levels not captured");

  a_reset_unlocked: assert property (
    $rose(rstn) |-> !syn_locked && !tag_locked)
    else $error("lock set after reset");

  c_ecc_capture: cover property (
    ecc_mode && fill_err && !syn_lock_r ##1 syn_locked);

  c_par_capture: cover property (
    !ecc_mode && fill_err && !syn_lock_r ##1 syn_locked);

  c_probe_lock: cover property (probe_err && !tag_lock_r ##1 tag_locked);

  c_shift_pair: cover property (tag_rd && tag_lock_r ##2 tag_rd);

  c_release_capture: cover property (fill_addr_read && fill_err && syn_lock_r ##1 syn_locked);

endmodule
`default_nettype wire

// file: cfec_pkg.sv
/*
 Constants, register indexes, field layouts and carrier types for the
 cache fill error capture block.
 Assumes one processor clock shared by all users of these types.
*/
`default_nettype none
package cfec_pkg;

  ////////////////////////////////////////////////////////////////////
  // Register indexes and widths
  localparam logic [4:0] IDX_FILL_ERROR_SYNDROME = 5'h13;
  localparam logic [4:0] IDX_TAG_CAPT  = 5'h14;
  localparam int         SYN_W         = 7;
  localparam int         TAG_W         = 17;
  localparam int         TAGREG_W      = 23;
  localparam int         RD_W          = 32;

  ////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int POS_CAPTURED_TAG_ADDR_PARITY = 22;
  localparam int POS_TAG_LO   = 5;
  localparam int POS_HI_SYN   = 7;
  localparam int POS_LO_SYN   = 0;
  localparam int PAR_BIT      = 0;
  localparam logic [2:0] SIZE_MAX = 3'h6;

  ////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [13:0] SYN_RST  = 14'h0000;
  localparam logic [22:0] TAG_RST  = 23'h00_0000;
  localparam logic        LOCK_RST = 1'b0;

  // Syndrome code of each data bit of a longword; check bit k gives 1<<k
  localparam logic [6:0] SYN_CODE [32] = '{
    7'h4F, 7'h4A, 7'h52, 7'h54, 7'h57, 7'h58, 7'h5B, 7'h5D,
    7'h23, 7'h25, 7'h26, 7'h29, 7'h2A, 7'h2C, 7'h31, 7'h34,
    7'h0E, 7'h0B, 7'h13, 7'h15, 7'h16, 7'h19, 7'h1A, 7'h1C,
    7'h62, 7'h64, 7'h67, 7'h68, 7'h6B, 7'h6D, 7'h70, 7'h75};

  ////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic        valid;
    logic [63:0] data;
    logic [13:0] check;
  } cfec_fill_t;

  typedef struct packed {
    logic        valid;
    logic        hit;
    logic        tag_par_err;
    logic        ctl_par_err;
    logic [16:0] tag;
    logic        tag_addr_parity_pin;
    logic        valid_status_pin;
    logic        shared_status_pin;
    logic        dirty_status_pin;
    logic        status_parity_pin;
  } cfec_probe_t;

  typedef struct packed {
    logic        captured_tag_addr_parity;
    logic [16:0] tag;
    logic        captured_valid_bit;
    logic        captured_shared_bit;
    logic        captured_dirty_bit;
    logic        captured_ctl_parity;
    logic        hit;
  } cfec_tag_t;

endpackage
`default_nettype wire

// file: cfec_syn_calc.sv
/*
 Syndrome or parity flag of one 32-bit longword of a fill.
 Assumes data and check bits are stable in the cycle they are used.
*/
`timescale 1ns/1ps
`default_nettype none
module cfec_syn_calc
  import cfec_pkg::*;
(
  input  wire logic [31:0]      data,
  input  wire logic [SYN_W-1:0] check,
  input  wire logic             ecc_mode,
  output logic      [SYN_W-1:0] syn
);

  logic [SYN_W-1:0] calc;
  logic             par_err;

  always_comb
  begin
    calc = 7'h00;
    for (int i = 0; i < 32; i++)
    begin
      if (data[i])
        calc = calc ^ SYN_CODE[i];
    end
    // Even parity over the longword and its parity pin
    par_err = ^{data, check[PAR_BIT]};
    if (ecc_mode)
      syn = calc ^ check;
    else
      syn = {6'h00, par_err};
  end

endmodule
`default_nettype wire

// file: cfec_ram_model.sv
/*
 Backup cache tag and data RAM model: drives fill quadwords and probes.
 Assumes the bench calls its tasks at the falling edge of clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module cfec_ram_model
  import cfec_pkg::*;
(
  input  wire logic      clk_sys,
  output var cfec_fill_t  fill_o,
  output var cfec_probe_t probe_o
);
  initial
  begin
    fill_o  = '0;
    probe_o = '0;
  end

  // Unstrobed lines carry inverted junk so stale data never matches
  task automatic send_fill(input logic [63:0] d, input logic [13:0] c);
  begin
    fill_o = '{1'b1, d, c};
    @(negedge clk_sys);
    fill_o = '{1'b0, ~d, ~c};
    // Idle cycle, so a following fill never rewrites the strobe at once
    @(negedge clk_sys);
  end
  endtask

  task automatic send_probe(input cfec_probe_t p);
    cfec_probe_t q;
  begin
    q       = ~p;
    q.valid = 1'b0;
    probe_o = p;
    @(negedge clk_sys);
    probe_o = q;
    @(negedge clk_sys);
  end
  endtask
endmodule
`default_nettype wire

// file: tb.sv
/*
 Self-checking bench for the fill error capture block.
 Assumes the RAM model supplies fills and probes on request.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    checks = checks + 1; \
    if ((got) !== (exp)) \
    begin \
      n_fail = n_fail + 1; \
      $display("CHECK FAILED at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end
module tb
  import cfec_pkg::*;
;
  logic              clk_sys;
  logic              rstn;
  logic              ecc_mode;
  logic [2:0]        cache_size_field;
  wire cfec_fill_t   fill_in;
  wire cfec_probe_t  probe_in;
  logic              fill_addr_read;
  logic              privileged_reg_read;
  logic              privileged_reg_write;
  logic [4:0]        reg_index;
  logic [RD_W-1:0]   rd_data;
  logic              rd_valid;
  logic              syn_locked;
  logic              tag_locked;
  logic [RD_W-1:0]   d;
  logic [22:0]       v;
  int                n_fail;
  int                checks;

  cfec_ram_model i_cfec_ram_model (
    .clk_sys (clk_sys),
    .fill_o  (fill_in),
    .probe_o (probe_in)
  );

  cfec_top i_cfec_top (
    .clk_sys              (clk_sys),
    .rstn                 (rstn),
    .ecc_mode             (ecc_mode),
    .cache_size_field     (cache_size_field),
    .fill_in              (fill_in),
    .probe_in             (probe_in),
    .fill_addr_read       (fill_addr_read),
    .privileged_reg_read  (privileged_reg_read),
    .privileged_reg_write (privileged_reg_write),
    .reg_index            (reg_index),
    .rd_data              (rd_data),
    .rd_valid             (rd_valid),
    .syn_locked           (syn_locked),
    .tag_locked           (tag_locked)
  );

  always #4 clk_sys = ~clk_sys;

  task automatic conclude;
  begin
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask

  ////////////////////////////////////////////////////////////////////
  // Register access; the trailing wait keeps tag reads an idle cycle apart
  task automatic rd(input logic [4:0] idx);
    int i;
  begin
    reg_index           = idx;
    privileged_reg_read = 1'b1;
    @(negedge clk_sys);
    privileged_reg_read = 1'b0;
    for (i = 0; i < 4 && rd_valid !== 1'b1; i++)
      @(negedge clk_sys);
    if (rd_valid !== 1'b1)
    begin
      n_fail = n_fail + 1;
      conclude();
    end
    d = rd_data;
    @(negedge clk_sys);
  end
  endtask

  task automatic rd_tag;
    int k;
  begin
    for (k = 0; k < 23; k++)
    begin
      rd(IDX_TAG_CAPT);
      v[k] = d[0];
    end
  end
  endtask

  task automatic wr(input logic [4:0] idx);
  begin
    reg_index            = idx;
    privileged_reg_write = 1'b1;
    @(negedge clk_sys);
    privileged_reg_write = 1'b0;
  end
  endtask

  task automatic unlock_syn;
  begin
    fill_addr_read = 1'b1;
    @(negedge clk_sys);
    fill_addr_read = 1'b0;
  end
  endtask

  task automatic fill(input logic [63:0] fd, input logic [13:0] fc);
  begin
    i_cfec_ram_model.send_fill(fd, fc);
  end
  endtask

  ////////////////////////////////////////////////////////////////////
  task automatic t_reset;
  begin
    `CHK({syn_locked, tag_locked}, 2'b00)
    rd(IDX_FILL_ERROR_SYNDROME);
    `CHK(d, 32'h0000_0000)
    `CHK(rd_valid, 1'b0)
    rd(5'h1F);
    `CHK(d, 32'h0000_0000)
    $display("done reset");
  end
  endtask

  task automatic t_ecc;
  begin
    ecc_mode = 1'b1;
    fill(64'h0000_0000_0000_0000, 14'h0000);
    `CHK(syn_locked, 1'b0)
    fill(64'h8000_0000_0000_0001, 14'h0000);
    `CHK({syn_locked, tag_locked}, 2'b11)
    fill(64'h0000_0000_0000_0000, 14'h0040);
    wr(IDX_FILL_ERROR_SYNDROME);
    rd(IDX_FILL_ERROR_SYNDROME);
    `CHK(d, 32'h0000_3ACF)
    unlock_syn();
    `CHK(syn_locked, 1'b0)
    fill(64'h0000_0000_0000_0000, 14'h2040);
    rd(IDX_FILL_ERROR_SYNDROME);
    `CHK(d, 32'h0000_2040)
    $display("done ecc");
  end
  endtask

  task automatic t_parity;
  begin
    ecc_mode = 1'b0;
    unlock_syn();
    fill(64'h0000_0003_0000_0003, 14'h0000);
    `CHK(syn_locked, 1'b0)
    fill(64'h0000_0001_0000_0000, 14'h0000);
    rd(IDX_FILL_ERROR_SYNDROME);
    `CHK(d, 32'h0000_0080)
    unlock_syn();
    fill(64'h0000_0000_0000_0001, 14'h0000);
    rd(IDX_FILL_ERROR_SYNDROME);
    `CHK(d, 32'h0000_0001)
    $display("done parity");
  end
  endtask

  task automatic t_tag;
  begin
    wr(IDX_TAG_CAPT);
    `CHK(tag_locked, 1'b0)
    i_cfec_ram_model.send_probe('{1'b1, 1'b1, 1'b0, 1'b0, 17'h1_5A5A,
                                  1'b1, 1'b0, 1'b1, 1'b0, 1'b1});
    rd_tag();
    `CHK(v, 23'h6B_4B4B)
    cache_size_field = 3'h3;
    i_cfec_ram_model.send_probe('{1'b1, 1'b0, 1'b1, 1'b0, 17'h1_FFFF,
                                  1'b0, 1'b1, 1'b0, 1'b0, 1'b0});
    `CHK(tag_locked, 1'b1)
    i_cfec_ram_model.send_probe('{1'b1, 1'b1, 1'b0, 1'b0, 17'h0_0000,
                                  1'b1, 1'b1, 1'b1, 1'b1, 1'b1});
    rd_tag();
    `CHK(v, 23'h3F_FF10)
    wr(IDX_TAG_CAPT);
    i_cfec_ram_model.send_probe('{1'b1, 1'b1, 1'b0, 1'b0, 17'h0_0000,
                                  1'b0, 1'b0, 1'b0, 1'b0, 1'b0});
    rd_tag();
    `CHK(v, 23'h00_0001)
    wr(IDX_TAG_CAPT);
    i_cfec_ram_model.send_probe('{1'b1, 1'b0, 1'b0, 1'b1, 17'h0_0000,
                                  1'b0, 1'b0, 1'b0, 1'b0, 1'b0});
    `CHK(tag_locked, 1'b1)
    $display("done tag");
  end
  endtask

  initial
  begin
    clk_sys              = 1'b0;
    rstn                 = 1'b0;
    ecc_mode             = 1'b1;
    cache_size_field     = 3'h0;
    fill_addr_read       = 1'b0;
    privileged_reg_read  = 1'b0;
    privileged_reg_write = 1'b0;
    reg_index            = 5'h00;
    n_fail               = 0;
    checks               = 0;
    repeat (6) @(negedge clk_sys);
    rstn = 1'b1;
    @(negedge clk_sys);
    t_reset();
    t_ecc();
    t_parity();
    t_tag();
    conclude();
  end
endmodule
`default_nettype wire
